// *** design/eip_pkg.sv ***
// package for the external pin interrupt block: register map, fields, resets
// assumes an apb slave with 32-bit data and one aligned word per register
package eip_pkg;

  // ==========================================================================
  // register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] ADDR_SENSE   = 8'h00;
  localparam logic [7:0] ADDR_MASK    = 8'h04;
  localparam logic [7:0] ADDR_FLAGS   = 8'h08;
  localparam logic [7:0] ADDR_CONTROL = 8'h0C;
  localparam logic [7:0] ADDR_STATUS  = 8'h10;

  // ==========================================================================
  // widths and reset values
  // ==========================================================================
  localparam int unsigned NUM_PINS   = 4;
  localparam int unsigned REG_W      = 8;
  localparam logic [7:0]  SENSE_RST  = 8'h00;
  localparam logic [3:0]  MASK_RST   = 4'h0;
  localparam logic [3:0]  FLAGS_RST  = 4'h0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // control register fields
  localparam int unsigned CTRL_GIE_BIT  = 0;
  localparam int unsigned CTRL_PD_BIT   = 1;
  localparam int unsigned CTRL_IOCK_BIT = 2;

  // ==========================================================================
  // sense modes
  // ==========================================================================
  typedef enum logic [1:0]
  {
    SENSE_LOW     = 2'b00,
    SENSE_CHANGE  = 2'b01,
    SENSE_FALLING = 2'b10,
    SENSE_RISING  = 2'b11
  } eip_sense_t;

  // wake sequencer states
  typedef enum logic [1:0]
  {
    WK_RUN     = 2'b00,
    WK_SAMPLE  = 2'b01,
    WK_STARTUP = 2'b10
  } eip_wake_t;

  // apb request bundle
  typedef struct packed
  {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } eip_apb_req_t;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned STARTUP_NS    = 4000;
  localparam int unsigned STARTUP_CYC   = (STARTUP_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned WDT_DIV_CYC   = 250;

endpackage : eip_pkg

// *** design/eip_pin_detect.sv ***
// one pin's sampler and edge/level detector
// assumes the pin is synchronous to pclk; edge logic runs only with io clock on
`timescale 1ns/1ps
`default_nettype none

module eip_pin_detect
(
  input  wire logic       pclk,      // system clock
  input  wire logic       presetn,   // async reset, active low
  input  wire logic       pin,       // request pin level
  input  wire logic       io_clk_on, // io clock running
  input  wire logic [1:0] sense,     // sense selection
  output var  logic       edge_hit,  // edge or change seen, one-cycle pulse
  output var  logic       level_low  // pin is low, read directly
);

  // ==========================================================================
  // sampling
  // ==========================================================================
  logic sample_ff;
  logic prev_ff;

  // two samples of the pin, the comparison between them finds edges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sample_ff <= 1'b1;
      prev_ff   <= 1'b1;
    end
    else if (io_clk_on)
    begin
      sample_ff <= pin;
      prev_ff   <= sample_ff;
    end
  end

  // ==========================================================================
  // detection
  // ==========================================================================
  // edge detection frozen when io clock is off, so no deep-sleep edges
  always_comb
  begin
    unique case (eip_pkg::eip_sense_t'(sense))
      eip_pkg::SENSE_LOW:     edge_hit = 1'b0;
      eip_pkg::SENSE_CHANGE:  edge_hit = io_clk_on & (sample_ff ^ prev_ff);
      eip_pkg::SENSE_FALLING: edge_hit = io_clk_on & prev_ff & ~sample_ff;
      eip_pkg::SENSE_RISING:  edge_hit = io_clk_on & ~prev_ff & sample_ff;
    endcase
  end

  // level path reads the pin directly so it works without the io clock
  assign level_low = ~pin;

endmodule : eip_pin_detect

`default_nettype wire

// *** design/eip_ctrl.sv ***
// external pin interrupt controller: four pins, apb registers, wake logic
// assumes pins synchronous to pclk; cpu supplies vector acknowledge pulses
//
// Contract
// - pin activity triggers even when pin drives
// - 00 low level, 01 any change
// - 10 falling edge, 11 rising edge
// - level request held while pin low
// - edges need running io clock
// - power-down level sampled twice before wake
// - level gone after samples: wake, no interrupt
// - forward only with global and mask enable
// - four pin edges registered independently
// - pin sampled before edge detection
// - mask bits 3..0 enable per pin
// - flag set on triggering edge or change
// - flag cleared when vector executes
// - writing one clears a flag
// - level-sensed pin keeps flag cleared
`timescale 1ns/1ps
`default_nettype none

module eip_ctrl
#(
  parameter int unsigned STARTUP_CYCLES = eip_pkg::STARTUP_CYC,  // wake start-up length
  parameter int unsigned WDT_DIV        = eip_pkg::WDT_DIV_CYC   // watchdog sample period
)
(
  input  wire logic        pclk,        // system clock, 250 MHz
  input  wire logic        presetn,     // async reset, active low
  input  wire logic        psel,        // apb select
  input  wire logic        penable,     // apb enable
  input  wire logic        pwrite,      // apb direction
  input  wire logic [7:0]  paddr,       // apb byte address
  input  wire logic [31:0] pwdata,      // apb write data
  output var  logic [31:0] prdata,      // apb read data
  output var  logic        pready,      // apb ready
  output var  logic        pslverr,     // apb error, unmapped address
  input  wire logic [3:0]  ext_request_pins, // request pins
  input  wire logic [3:0]  vector_ack,  // cpu executes vector n, pulse
  output var  logic [3:0]  irq_req,     // per-pin request to cpu
  output var  logic        wake_up      // wake pulse out of power-down
);

  // ==========================================================================
  // elaboration checks
  // ==========================================================================
  if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 65535)
  begin : g_bad_startup
    $error("STARTUP_CYCLES out of range");
  end
  if (WDT_DIV < 2 || WDT_DIV > 65535)
  begin : g_bad_div
    $error("WDT_DIV out of range");
  end

  localparam logic [15:0] STARTUP_LAST = 16'(STARTUP_CYCLES - 1);
  localparam logic [15:0] WDT_LAST     = 16'(WDT_DIV - 1);

  // ==========================================================================
  // register state
  // ==========================================================================
  logic [7:0]  sense_ff;
  logic [3:0]  mask_ff;
  logic [3:0]  flags_ff;
  logic        gie_ff;
  logic        pd_ff;
  logic        iock_ff;
  logic [31:0] nxt_prdata;
  logic        nxt_pslverr;
  eip_pkg::eip_apb_req_t req;
  logic        wr_acc;
  logic        rd_acc;
  logic        mapped;

  assign req    = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
  assign wr_acc = req.sel & req.enable & req.write & pready;
  assign rd_acc = req.sel & ~req.enable & ~req.write;

  // address decode used by reads and writes
  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ref_a);
    is_addr = (a == ref_a);
  endfunction : is_addr

  assign mapped = is_addr(req.addr, eip_pkg::ADDR_SENSE) | is_addr(req.addr, eip_pkg::ADDR_MASK)
                | is_addr(req.addr, eip_pkg::ADDR_FLAGS) | is_addr(req.addr, eip_pkg::ADDR_CONTROL)
                | is_addr(req.addr, eip_pkg::ADDR_STATUS);

  // ==========================================================================
  // per-pin detectors
  // ==========================================================================
  logic [3:0] edge_hit;
  logic [3:0] level_low;
  logic [3:0] is_level;

  // each pin has its own sampler so edges register independently
  for (genvar i = 0; i < eip_pkg::NUM_PINS; i++)
  begin : g_pin
    eip_pin_detect u_det
    (
      .pclk      (pclk),
      .presetn   (presetn),
      .pin       (ext_request_pins[i]),
      .io_clk_on (iock_ff),
      .sense     (sense_ff[2*i +: 2]),
      .edge_hit  (edge_hit[i]),
      .level_low (level_low[i])
    );
    assign is_level[i] = (sense_ff[2*i +: 2] == 2'(eip_pkg::SENSE_LOW));
  end

  // ==========================================================================
  // configuration registers
  // ==========================================================================
  // sense, mask, control: plain read/write; upper mask bits are not stored
  // a control write in the wake cycle wins over the hardware power-down clear,
  // so that write is kept; a wake with no control write in its cycle clears pd
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sense_ff <= eip_pkg::SENSE_RST;
      mask_ff  <= eip_pkg::MASK_RST;
      gie_ff   <= 1'b0;
      pd_ff    <= 1'b0;
      iock_ff  <= 1'b1;
    end
    else
    begin
      if (wr_acc && is_addr(req.addr, eip_pkg::ADDR_SENSE))
        sense_ff <= req.wdata[7:0];
      if (wr_acc && is_addr(req.addr, eip_pkg::ADDR_MASK))
        mask_ff <= req.wdata[3:0];
      if (wr_acc && is_addr(req.addr, eip_pkg::ADDR_CONTROL))
      begin
        gie_ff  <= req.wdata[eip_pkg::CTRL_GIE_BIT];
        pd_ff   <= req.wdata[eip_pkg::CTRL_PD_BIT];
        iock_ff <= req.wdata[eip_pkg::CTRL_IOCK_BIT];
      end
      else if (wake_up)
        pd_ff <= 1'b0;                                // wake leaves power-down
    end
  end

  // ==========================================================================
  // pending flags
  // ==========================================================================
  logic [3:0] w1c;
  assign w1c = (wr_acc && is_addr(req.addr, eip_pkg::ADDR_FLAGS)) ? req.wdata[3:0] : 4'h0;

  // set wins over clear so an edge during a clear is never lost
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_ff <= eip_pkg::FLAGS_RST;
    else
      flags_ff <= ((flags_ff & ~w1c & ~vector_ack) | edge_hit) & ~is_level;
  end

  // ==========================================================================
  // power-down wake sequencer
  // ==========================================================================
  eip_pkg::eip_wake_t wk_ff;
  logic [15:0] wdt_cnt_ff;
  logic [15:0] su_cnt_ff;
  logic [1:0]  hits_ff;
  logic        wdt_tick;
  logic [3:0]  wake_lvl;
  logic        level_ok_ff;

  assign wdt_tick = (wdt_cnt_ff == WDT_LAST);
  assign wake_lvl = level_low & is_level & mask_ff;

  // slow watchdog-rate sample tick, free running
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wdt_cnt_ff <= 16'h0000;
    else
      wdt_cnt_ff <= wdt_tick ? 16'h0000 : wdt_cnt_ff + 16'h0001;
  end

  // two watchdog samples, then a start-up wait before the cpu runs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wk_ff       <= eip_pkg::WK_RUN;
      hits_ff     <= 2'b00;
      su_cnt_ff   <= 16'h0000;
      wake_up     <= 1'b0;
      level_ok_ff <= 1'b1;
    end
    else
    begin
      wake_up <= 1'b0;
      unique case (wk_ff)
        eip_pkg::WK_RUN:
        begin
          hits_ff <= 2'b00;
          if (pd_ff && !wake_up)
            wk_ff <= eip_pkg::WK_SAMPLE;
        end
        eip_pkg::WK_SAMPLE:
        begin
          if (!pd_ff)
            wk_ff <= eip_pkg::WK_RUN;
          else if (wdt_tick)
          begin
            if (wake_lvl == 4'h0)
              hits_ff <= 2'b00;
            else if (hits_ff == 2'b01)
            begin
              wk_ff       <= eip_pkg::WK_STARTUP;
              su_cnt_ff   <= 16'h0000;
              level_ok_ff <= 1'b0;
            end
            else
              hits_ff <= 2'b01;
          end
        end
        eip_pkg::WK_STARTUP:
        begin
          su_cnt_ff <= su_cnt_ff + 16'h0001;
          if (su_cnt_ff == STARTUP_LAST)
          begin
            wk_ff       <= eip_pkg::WK_RUN;
            wake_up     <= 1'b1;
            level_ok_ff <= 1'b1;
          end
        end
        default:
          wk_ff <= eip_pkg::WK_RUN;
      endcase
    end
  end

  // ==========================================================================
  // request output
  // ==========================================================================
  logic [3:0] active;
  // level requests only once awake; a vanished wake level yields none
  assign active = (level_low & is_level & {4{~pd_ff & level_ok_ff}})
                | (flags_ff & ~is_level);

  // global and per-pin enable both required
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_req <= 4'h0;
    else
      irq_req <= active & mask_ff & {4{gie_ff}};
  end

  // ==========================================================================
  // apb slave
  // ==========================================================================
  // read data latched in the setup cycle; zero wait states
  always_comb
  begin
    nxt_prdata  = eip_pkg::RDATA_ZERO;
    nxt_pslverr = 1'b0;
    if (rd_acc)
    begin
      if (is_addr(req.addr, eip_pkg::ADDR_SENSE))
        nxt_prdata[7:0] = sense_ff;
      else if (is_addr(req.addr, eip_pkg::ADDR_MASK))
        nxt_prdata[3:0] = mask_ff;
      else if (is_addr(req.addr, eip_pkg::ADDR_FLAGS))
        nxt_prdata[3:0] = flags_ff;
      else if (is_addr(req.addr, eip_pkg::ADDR_CONTROL))
        nxt_prdata[2:0] = {iock_ff, pd_ff, gie_ff};
      else if (is_addr(req.addr, eip_pkg::ADDR_STATUS))
        nxt_prdata[5:0] = {wk_ff, level_low};
    end
    if (req.sel && !req.enable && !mapped)
      nxt_pslverr = 1'b1;
  end

  // ready and error rise for the access phase only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= eip_pkg::RDATA_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= req.sel & ~req.enable;
      pslverr <= nxt_pslverr;
      if (rd_acc)
        prdata <= nxt_prdata;
    end
  end

endmodule : eip_ctrl

`default_nettype wire

// *** tb/eip_pin_src.sv ***
// model of the external sources that drive the four request pins
// assumes the bench asks for each new pin level just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module eip_pin_src
(
  input  wire logic       pclk,    // clock
  input  wire logic       presetn, // reset, active low
  input  wire logic [3:0] want,    // level each source heads for
  input  wire logic [3:0] slow,    // sources that answer a cycle late
  output var  logic [3:0] pins     // request pins
);
  logic [3:0] lag_ff;
  logic [3:0] pins_ff;
  // ==========
  // sources idle high; a level is held whole, never as a one-cycle glitch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lag_ff  <= 4'hF;
      pins_ff <= 4'hF;
    end
    else
    begin
      lag_ff  <= want;
      pins_ff <= (slow & lag_ff) | (~slow & want);
    end
  end
  assign pins = pins_ff;
endmodule : eip_pin_src
`default_nettype wire

// *** tb/eip_ctrl_props.sv ***
// assertions on the ports of eip_ctrl, bound below the checker
// assumes sense is rewritten only while the pin is masked
`timescale 1ns/1ps
`default_nettype none
module eip_ctrl_props
(
  input wire logic        pclk,             // clock
  input wire logic        presetn,          // reset, active low
  input wire logic        psel,             // apb select
  input wire logic        penable,          // apb enable
  input wire logic        pwrite,           // apb direction
  input wire logic [7:0]  paddr,            // apb address
  input wire logic [31:0] pwdata,           // apb write data
  input wire logic [31:0] prdata,           // apb read data
  input wire logic        pready,           // apb ready
  input wire logic [3:0]  ext_request_pins, // request pins
  input wire logic [3:0]  irq_req,          // requests
  input wire logic        wake_up           // wake pulse
);
  logic [7:0] sense_ff;
  logic [3:0] mask_ff;
  logic [2:0] ctrl_ff;
  logic       wr;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // shadow of what software wrote; power-down ends with the wake pulse
  assign wr = psel && penable && pready && pwrite;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sense_ff <= 8'h00;
      mask_ff  <= 4'h0;
      ctrl_ff  <= 3'h4;
    end
    else
    begin
      if (wr && paddr == eip_pkg::ADDR_SENSE)
        sense_ff <= pwdata[7:0];
      if (wr && paddr == eip_pkg::ADDR_MASK)
        mask_ff <= pwdata[3:0];
      if (wr && paddr == eip_pkg::ADDR_CONTROL)
        ctrl_ff <= pwdata[2:0];
      else if (wake_up)
        ctrl_ff[1] <= 1'b0;
    end
  end
  // ==========
  // register and global checks
  AST_GIE_GATE: assert property (
    !ctrl_ff[0] [*3] |-> irq_req == 4'h0) else $error("request without global enable");
  AST_MASK_RD: assert property (
    pready && !pwrite && paddr == eip_pkg::ADDR_MASK |-> prdata == {28'h000_0000, mask_ff})
    else $error("mask read back wrong");
  AST_RD_ZERO: assert property (
    pready && !pwrite && paddr == eip_pkg::ADDR_FLAGS |-> prdata[31:4] == 28'h000_0000)
    else $error("unused flag bits not zero");
  AST_WAKE_PD: assert property (
    wake_up |-> ctrl_ff[1] ##1 !wake_up) else $error("wake outside power-down");
  // ==========
  // per-pin sense checks; the wait allows the sampler and flag stages
  for (genvar i = 0; i < 4; i++)
  begin : g_pin
    logic [1:0] s;
    logic       on;
    logic       lo_on;
    assign s     = sense_ff[2*i+:2];
    assign on    = mask_ff[i] && ctrl_ff[0] && ctrl_ff[2];
    assign lo_on = s == 2'h0 && !ext_request_pins[i] && on && !ctrl_ff[1];
    AST_FALL: assert property (
      $fell(ext_request_pins[i]) && s == 2'h2 && on |-> ##[1:5] irq_req[i])
      else $error("falling edge raised no request");
    AST_RISE: assert property (
      $rose(ext_request_pins[i]) && s == 2'h3 && on |-> ##[1:5] irq_req[i])
      else $error("rising edge raised no request");
    AST_CHG: assert property (
      $changed(ext_request_pins[i]) && s == 2'h1 && on |-> ##[1:5] irq_req[i])
      else $error("change raised no request");
    AST_LVL_HOLD: assert property (
      lo_on [*5] |-> irq_req[i]) else $error("low level not requesting");
    AST_LVL_REL: assert property (
      (s == 2'h0 && ext_request_pins[i]) [*5] |-> !irq_req[i])
      else $error("level request with pin high");
    AST_MASK_GATE: assert property (
      !mask_ff[i] [*3] |-> !irq_req[i]) else $error("request while masked");
  end
endmodule : eip_ctrl_props
bind eip_ctrl eip_ctrl_props eip_ctrl_props_i
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .ext_request_pins, .irq_req, .wake_up
);
`default_nettype wire

// *** tb/tb_eip_ctrl.sv ***
// self-checking bench for eip_ctrl: registers, sense modes, gating, wake
// assumes eip_pin_src and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module tb_eip_ctrl;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, wake_up, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pins, want, slow, vector_ack, irq_req;
  int          n_errors, checks, cyc;
  // short counts keep the wake sequence quick
  eip_ctrl #(.STARTUP_CYCLES(20), .WDT_DIV(2)) eip_ctrl_i
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ext_request_pins(pins), .vector_ack, .irq_req, .wake_up
  );
  eip_pin_src eip_pin_src_i (.pclk, .presetn, .want, .slow, .pins);
  // ==========
  // clock and hang guard
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_errors++;
      summarize();
    end
  end
  // ==========
  // helpers
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_sig(input logic [3:0] got, input logic [3:0] exp);
    chk_reg({28'h000_0000, got}, {28'h000_0000, exp});
  endtask : chk_sig
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1)
      n_errors++;
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask : tick
  task automatic wait_wake();
    int n;
    n = 0;
    while (wake_up !== 1'b1 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    chk_sig({3'h0, wake_up}, 4'h1);
  endtask : wait_wake
  // does a pin move raise a flag in sense mode m
  function automatic logic hit(input logic [1:0] m, input logic fall);
    return (m == 2'h1) || (m == {1'b1, !fall});
  endfunction : hit
  // mask off, new sense, stale flags cleared, mask on
  task automatic setup(input logic [31:0] sense);
    apb(1, eip_pkg::ADDR_MASK, 32'h0000_0000);
    apb(1, eip_pkg::ADDR_SENSE, sense);
    apb(1, eip_pkg::ADDR_FLAGS, 32'h0000_000F);
    apb(1, eip_pkg::ADDR_MASK, 32'h0000_000F);
  endtask : setup
  // ==========
  // main sequence
  initial
  begin
    int          p;
    logic [1:0]  m;
    logic [31:0] rnd;
    {cyc, n_errors, checks} = '0;
    {presetn, psel, penable, pwrite, paddr, pwdata, slow, vector_ack} = '0;
    want = 4'hF;
    void'($urandom(28287));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 3; a++)
    begin
      apb(0, 8'(4 * a), 32'h0000_0000);
      chk_reg(rd, 32'h0000_0000);
    end
    apb(0, 8'h14, 32'h0000_0000);
    chk_reg({rd[31:1], err}, 32'h0000_0001);
    apb(1, eip_pkg::ADDR_MASK, 32'hFFFF_FFFF);
    apb(0, eip_pkg::ADDR_MASK, 32'h0000_0000);
    chk_reg(rd, 32'h0000_000F);
    // random sense only with every pin masked off
    rnd = $urandom;
    apb(1, eip_pkg::ADDR_MASK, 32'h0000_0000);
    apb(1, eip_pkg::ADDR_SENSE, rnd);
    apb(0, eip_pkg::ADDR_SENSE, 32'h0000_0000);
    chk_reg(rd, {24'h00_0000, rnd[7:0]});
    // each edge mode, a random pin falling then rising
    for (int k = 1; k < 4; k++)
    begin
      m    = 2'(k);
      p    = $urandom_range(3);
      slow <= 4'($urandom);
      setup({24'h00_0000, {4{m}}});
      apb(1, eip_pkg::ADDR_CONTROL, 32'h0000_0005);
      for (int f = 1; f >= 0; f--)
      begin
        want[p] <= !f;
        tick(8);
        apb(0, eip_pkg::ADDR_FLAGS, 32'h0000_0000);
        chk_reg(rd, 32'(hit(m, f)) << p);
        chk_sig(irq_req, 4'(hit(m, f)) << p);
        apb(1, eip_pkg::ADDR_CONTROL, 32'h0000_0004);
        tick(1);
        chk_sig(irq_req, 4'h0);
        apb(1, eip_pkg::ADDR_CONTROL, 32'h0000_0005);
        if (f)
          apb(1, eip_pkg::ADDR_FLAGS, 32'h0000_0001 << p);
        else
        begin
          vector_ack <= 4'h1 << p;
          @(posedge pclk);
          vector_ack <= 4'h0;
        end
        tick(2);
        apb(0, eip_pkg::ADDR_FLAGS, 32'h0000_0000);
        chk_reg(rd, 32'h0000_0000);
      end
    end
    // edges ignored with the io clock stopped, then all four pins at once
    setup(32'h0000_00AA);
    apb(1, eip_pkg::ADDR_CONTROL, 32'h0000_0001);
    want <= 4'h0;
    tick(8);
    want <= 4'hF;
    tick(8);
    apb(1, eip_pkg::ADDR_CONTROL, 32'h0000_0005);
    apb(0, eip_pkg::ADDR_FLAGS, 32'h0000_0000);
    chk_reg(rd, 32'h0000_0000);
    want <= 4'h0;
    tick(8);
    apb(0, eip_pkg::ADDR_FLAGS, 32'h0000_0000);
    chk_reg(rd, 32'h0000_000F);
    want <= 4'hF;
    // low level: request while low, flags held clear
    setup(32'h0000_0000);
    want <= ~(4'h1 << p);
    tick(12);
    chk_sig(irq_req, 4'h1 << p);
    apb(0, eip_pkg::ADDR_FLAGS, 32'h0000_0000);
    chk_reg(rd, 32'h0000_0000);
    apb(0, eip_pkg::ADDR_STATUS, 32'h0000_0000);
    chk_reg(rd, 32'h0000_0001 << p);
    want <= 4'hF;
    tick(6);
    chk_sig(irq_req, 4'h0);
    // power-down: held level wakes and requests; short level wakes only
    apb(1, eip_pkg::ADDR_CONTROL, 32'h0000_0007);
    want <= ~(4'h1 << p);
    wait_wake();
    tick(8);
    chk_sig(irq_req, 4'h1 << p);
    apb(0, eip_pkg::ADDR_CONTROL, 32'h0000_0000);
    chk_reg(rd, 32'h0000_0005);
    want <= 4'hF;
    tick(4);
    apb(1, eip_pkg::ADDR_CONTROL, 32'h0000_0007);
    want <= ~(4'h1 << p);
    tick(10);
    want <= 4'hF;
    wait_wake();
    tick(4);
    chk_sig(irq_req, 4'h0);
    summarize();
  end
endmodule : tb_eip_ctrl
`default_nettype wire
